/* hdl/dtc_pin_edge.sv */
/*
  Synchroniser and falling-edge detector for the external count pins.
  Assumes pins may change at any time; one pulse per falling edge, three clocks late.
*/
`timescale 1ns/1ps
module dtc_pin_edge #(
  parameter int unsigned N = dtc_pkg::COUNT_PIN_N
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Pins and edges
  input  wire logic [N-1:0] pin_in,
  output logic      [N-1:0] pin_fall
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
    logic [N-1:0] fall;
  } dtc_edge_t;

  dtc_edge_t st;
  dtc_edge_t next_st;

  if (N < 1)
  begin : g_bad_n
    $error("dtc_pin_edge needs at least one pin");
  end

  always_comb
  begin
    next_st      = st;
    next_st.meta = pin_in;
    next_st.sync = st.meta;
    // Only the second stage is compared, the first may still be settling
    next_st.prev = st.sync;
    next_st.fall = st.prev & ~st.sync;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pin_fall = st.fall;

endmodule : dtc_pin_edge

/* hdl/dtc_pkg.sv */
/*
  Shared constants and types of the dual timer/counter pair: register indices,
  field positions, reset values, timing counts, the mode encoding and state structs.
  Assumes an AHB-Lite slave with byte address equal to four times the register index.
*/
package dtc_pkg;

  // Address decode
  localparam int unsigned ADDR_W = 10;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_TIMER_RUN_FLAGS    = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE_CONTROL = 8'h89;
  localparam logic [7:0] IDX_TIMER_A_LOW_BYTE   = 8'h8a;
  localparam logic [7:0] IDX_TIMER_B_LOW_BYTE   = 8'h8b;
  localparam logic [7:0] IDX_TIMER_A_HIGH_BYTE  = 8'h8c;
  localparam logic [7:0] IDX_TIMER_B_HIGH_BYTE  = 8'h8d;

  // Fields of timer_mode_control
  localparam int unsigned B_GATING_BIT = 7;
  localparam int unsigned B_SOURCE_BIT = 6;
  localparam int unsigned B_MODE_LSB   = 4;
  localparam int unsigned A_GATING_BIT = 3;
  localparam int unsigned A_SOURCE_BIT = 2;
  localparam int unsigned A_MODE_LSB   = 0;

  // Fields of the run and flag register
  localparam int unsigned B_OVF_BIT = 7;
  localparam int unsigned B_RUN_BIT = 6;
  localparam int unsigned A_OVF_BIT = 5;
  localparam int unsigned A_RUN_BIT = 4;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Timer mode increments once per this many system clocks
  localparam int unsigned TIMER_CLK_DIV = 2;

  // Prescaler width in mode 00
  localparam int unsigned PRESCALE_W = 5;

  // Pin count of the edge detector: count pins of timer A and B
  localparam int unsigned COUNT_PIN_N = 2;

  typedef enum logic [1:0] {
    DTC_MODE_PRESCALE = 2'h0,
    DTC_MODE_16BIT    = 2'h1,
    DTC_MODE_RELOAD   = 2'h2,
    DTC_MODE_SPLIT    = 2'h3
  } dtc_mode_t;

  typedef struct packed {
    logic timer_b_gate_pin;
    logic timer_a_gate_pin;
    logic timer_b_count_pin;
    logic timer_a_count_pin;
  } dtc_pins_t;

  typedef struct packed {
    logic timer_b_vector_ack;
    logic timer_a_vector_ack;
  } dtc_ack_t;

  typedef struct packed {
    logic [7:0]  timer_mode_control;
    logic [7:0]  timer_a_low_byte;
    logic [7:0]  timer_a_high_byte;
    logic [7:0]  timer_b_low_byte;
    logic [7:0]  timer_b_high_byte;
    logic        timer_a_run;
    logic        timer_b_run;
    logic        timer_a_overflow_flag;
    logic        timer_b_overflow_flag;
    logic [7:0]  div_cnt;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } dtc_state_t;

  localparam dtc_state_t STATE_RST = '{
    timer_mode_control: MODE_RST,
    timer_a_low_byte:   BYTE_RST,
    timer_a_high_byte:  BYTE_RST,
    timer_b_low_byte:   BYTE_RST,
    timer_b_high_byte:  BYTE_RST,
    hreadyout:          1'b1,
    default:            '0
  };

endpackage : dtc_pkg

/* hdl/dtc_timer_pair.sv */
/*
  Two timer/counters, A and B, with pin gating, timer or counter source and four modes,
  reached as an AHB-Lite slave with zero wait states.
  Assumes gate pins synchronous to hclk, single word transfers, and one pulse per
  interrupt vector on the acknowledge inputs.
*/
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
module dtc_timer_pair #(
  parameter int unsigned CLK_DIV = dtc_pkg::TIMER_CLK_DIV
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // External count and gate pins
  input  wire dtc_pkg::dtc_pins_t timer_pins,
  // Vector taken, one pulse each
  input  wire dtc_pkg::dtc_ack_t  vector_ack,
  // Overflow flags
  output logic                   timer_a_overflow_flag,
  output logic                   timer_b_overflow_flag
);
  import dtc_pkg::*;

  if (CLK_DIV < 1 || CLK_DIV > 256)
  begin : g_bad_div
    $error("CLK_DIV must lie between 1 and 256");
  end

  localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);

  dtc_state_t               st;
  dtc_state_t               next_st;
  logic [COUNT_PIN_N-1:0]   pin_fall;

  // Counter-mode edges, three clocks behind the pin
  dtc_pin_edge #(
    .N (COUNT_PIN_N)
  ) u_edge (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_in   ({timer_pins.timer_b_count_pin, timer_pins.timer_a_count_pin}),
    .pin_fall (pin_fall)
  );

  // One counting step; returns {overflow, high, low}
  function automatic logic [16:0] count_step(
    input dtc_mode_t  mode,
    input logic       inc,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [16:0] res;
    logic [16:0] wide;
    res  = {1'b0, hi, lo};
    wide = 17'({hi, lo}) + 17'h00001;
    if (inc)
    begin
      case (mode)
        DTC_MODE_PRESCALE:
        begin
          // Prescaler carries into the high byte; upper low-byte bits untouched
          if (lo[PRESCALE_W-1:0] == {PRESCALE_W{1'b1}})
          begin
            res = {(hi == 8'hff), 8'(hi + 8'h01), lo[7:PRESCALE_W], {PRESCALE_W{1'b0}}};
          end
          else
          begin
            res = {1'b0, hi, lo[7:PRESCALE_W], PRESCALE_W'(lo[PRESCALE_W-1:0] + 1'b1)};
          end
        end
        DTC_MODE_16BIT:
        begin
          res = wide;
        end
        DTC_MODE_RELOAD:
        begin
          if (lo == 8'hff)
          begin
            res = {1'b1, hi, hi};
          end
          else
          begin
            res = {1'b0, hi, 8'(lo + 8'h01)};
          end
        end
        DTC_MODE_SPLIT:
        begin
          // Low byte alone; the high byte is stepped by the caller
          res = {(lo == 8'hff), hi, 8'(lo + 8'h01)};
        end
        default:
        begin
          res = {1'b0, hi, lo};
        end
      endcase
    end
    return res;
  endfunction : count_step

  // Register read view of a state
  function automatic logic [7:0] reg_read(
    input logic [7:0]  idx,
    input dtc_state_t  s
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_TIMER_RUN_FLAGS:
      begin
        v[B_OVF_BIT] = s.timer_b_overflow_flag;
        v[B_RUN_BIT] = s.timer_b_run;
        v[A_OVF_BIT] = s.timer_a_overflow_flag;
        v[A_RUN_BIT] = s.timer_a_run;
      end
      IDX_TIMER_MODE_CONTROL:
      begin
        v = s.timer_mode_control;
      end
      IDX_TIMER_A_LOW_BYTE:
      begin
        v = s.timer_a_low_byte;
      end
      IDX_TIMER_B_LOW_BYTE:
      begin
        v = s.timer_b_low_byte;
      end
      IDX_TIMER_A_HIGH_BYTE:
      begin
        v = s.timer_a_high_byte;
      end
      IDX_TIMER_B_HIGH_BYTE:
      begin
        v = s.timer_b_high_byte;
      end
      default:
      begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : reg_read

  always_comb
  begin
    logic        tick;
    dtc_mode_t   mode_a;
    dtc_mode_t   mode_b;
    logic        src_a;
    logic        src_b;
    logic        en_a;
    logic        en_b;
    logic        inc_a;
    logic        inc_b;
    logic        inc_split_hi;
    logic [16:0] res_a;
    logic [16:0] res_b;
    logic        set_a;
    logic        set_b;
    logic        addr_ok;
    logic [7:0]  addr_idx;
    logic [7:0]  wdat;

    // Every local starts defined, so no path can leave a latch behind
    tick         = 1'b0;
    mode_a       = DTC_MODE_PRESCALE;
    mode_b       = DTC_MODE_PRESCALE;
    src_a        = 1'b0;
    src_b        = 1'b0;
    en_a         = 1'b0;
    en_b         = 1'b0;
    inc_a        = 1'b0;
    inc_b        = 1'b0;
    inc_split_hi = 1'b0;
    res_a        = 17'h00000;
    res_b        = 17'h00000;
    set_a        = 1'b0;
    set_b        = 1'b0;
    addr_ok      = 1'b0;
    addr_idx     = 8'h00;

    next_st           = st;
    next_st.hreadyout = 1'b1;
    next_st.hresp     = 1'b0;
    wdat              = hwdata[7:0];

    // Divider for the timer-mode rate
    tick = 1'b0;
    if (st.div_cnt == DIV_LAST)
    begin
      next_st.div_cnt = 8'h00;
      tick            = 1'b1;
    end
    else
    begin
      next_st.div_cnt = st.div_cnt + 8'h01;
    end

    mode_a = dtc_mode_t'(st.timer_mode_control[A_MODE_LSB +: 2]);
    mode_b = dtc_mode_t'(st.timer_mode_control[B_MODE_LSB +: 2]);

    src_a = st.timer_mode_control[A_SOURCE_BIT] ? pin_fall[0] : tick;
    src_b = st.timer_mode_control[B_SOURCE_BIT] ? pin_fall[1] : tick;

    en_a = st.timer_a_run &
           (~st.timer_mode_control[A_GATING_BIT] | timer_pins.timer_a_gate_pin);
    en_b = st.timer_b_run &
           (~st.timer_mode_control[B_GATING_BIT] | timer_pins.timer_b_gate_pin);

    inc_a = en_a & src_a;
    inc_b = en_b & src_b & (mode_b != DTC_MODE_SPLIT);

    res_a = count_step(mode_a, inc_a, st.timer_a_low_byte, st.timer_a_high_byte);
    res_b = count_step(mode_b, inc_b, st.timer_b_low_byte, st.timer_b_high_byte);

    next_st.timer_a_low_byte  = res_a[7:0];
    next_st.timer_a_high_byte = res_a[15:8];
    next_st.timer_b_low_byte  = res_b[7:0];
    next_st.timer_b_high_byte = res_b[15:8];

    // Split mode: A high byte is a plain timer run by B's run bit, owning B's flag
    inc_split_hi = (mode_a == DTC_MODE_SPLIT) & st.timer_b_run & tick;
    set_a        = res_a[16];
    if (mode_a == DTC_MODE_SPLIT)
    begin
      set_b = inc_split_hi & (st.timer_a_high_byte == 8'hff);
      if (inc_split_hi)
      begin
        next_st.timer_a_high_byte = st.timer_a_high_byte + 8'h01;
      end
    end
    else
    begin
      set_b = res_b[16];
    end

    // Vector taken clears the flag
    if (vector_ack.timer_a_vector_ack)
    begin
      next_st.timer_a_overflow_flag = 1'b0;
    end
    if (vector_ack.timer_b_vector_ack)
    begin
      next_st.timer_b_overflow_flag = 1'b0;
    end

    // Data phase of a write; a software write beats a count in the same cycle
    if (st.wr_pend)
    begin
      next_st.wr_pend = 1'b0;
      case (st.wr_idx)
        IDX_TIMER_RUN_FLAGS:
        begin
          next_st.timer_b_overflow_flag = wdat[B_OVF_BIT];
          next_st.timer_b_run           = wdat[B_RUN_BIT];
          next_st.timer_a_overflow_flag = wdat[A_OVF_BIT];
          next_st.timer_a_run           = wdat[A_RUN_BIT];
        end
        IDX_TIMER_MODE_CONTROL:
        begin
          next_st.timer_mode_control = wdat;
        end
        IDX_TIMER_A_LOW_BYTE:
        begin
          next_st.timer_a_low_byte = wdat;
        end
        IDX_TIMER_B_LOW_BYTE:
        begin
          next_st.timer_b_low_byte = wdat;
        end
        IDX_TIMER_A_HIGH_BYTE:
        begin
          next_st.timer_a_high_byte = wdat;
        end
        IDX_TIMER_B_HIGH_BYTE:
        begin
          next_st.timer_b_high_byte = wdat;
        end
        default:
        begin
          next_st.wr_pend = 1'b0;
        end
      endcase
    end

    // Hardware set wins over any clear in the same cycle
    if (set_a)
    begin
      next_st.timer_a_overflow_flag = 1'b1;
    end
    if (set_b)
    begin
      next_st.timer_b_overflow_flag = 1'b1;
    end

    // Address phase; read data taken from the next state so a write just before shows
    addr_idx = haddr[ADDR_W-1:2];
    addr_ok  = hsel & hready & htrans[1] & (haddr[1:0] == 2'h0);
    if (hsel & hready & htrans[1] & hwrite)
    begin
      next_st.wr_pend = addr_ok;
      next_st.wr_idx  = addr_idx;
    end
    else if (hsel & hready & htrans[1])
    begin
      next_st.hrdata = {24'h000000, addr_ok ? reg_read(addr_idx, next_st) : 8'h00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= STATE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output straight from the state register
  assign hrdata                = st.hrdata;
  assign hreadyout             = st.hreadyout;
  assign hresp                 = st.hresp;
  assign timer_a_overflow_flag = st.timer_a_overflow_flag;
  assign timer_b_overflow_flag = st.timer_b_overflow_flag;

  // hsize is unused: every access is treated as a whole word
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule : dtc_timer_pair

/* verif/dtc_assertions.sv */
/*
  Port checker of the timer pair: bus answers, register readback, flag causes.
  Assumes hready is the slave's own hreadyout.
*/
`timescale 1ns/1ps
module dtc_assertions
  import dtc_pkg::*;
#(
  parameter int unsigned CLK_DIV = 2
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Acks and flags
  input wire dtc_ack_t    vector_ack,
  input wire logic        timer_a_overflow_flag,
  input wire logic        timer_b_overflow_flag
);
  import dtc_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       ap;
  logic       wr_m;
  logic       wr_r;
  logic [7:0] mode_sh;
  logic [1:0] run_sh;
  assign ap = hsel && hready && htrans[1];
  // Shadows follow software writes only, so they stay honest against the design
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {wr_m, wr_r, mode_sh, run_sh} <= '0;
    end
    else
    begin
      wr_m <= ap && hwrite && haddr[9:0] == {IDX_TIMER_MODE_CONTROL, 2'b00};
      wr_r <= ap && hwrite && haddr[9:0] == {IDX_TIMER_RUN_FLAGS, 2'b00};
      if (wr_m) mode_sh <= hwdata[7:0];
      if (wr_r) run_sh <= {hwdata[6], hwdata[4]};
    end
  chk_ready_high: assert property (hreadyout) else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_mode_read: assert property (ap && !hwrite && haddr[9:0] == {IDX_TIMER_MODE_CONTROL, 2'b00}
    |=> hrdata[7:0] == mode_sh) else $error("mode readback differs");
  chk_unmapped_zero: assert property (ap && !hwrite && haddr[9:0] == 10'h3fc
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_run_read: assert property (ap && !hwrite && haddr[9:0] == {IDX_TIMER_RUN_FLAGS, 2'b00}
    |=> hrdata[6] == run_sh[1] && hrdata[4] == run_sh[0] && hrdata[3:0] == 4'h0)
    else $error("run bits readback differs");
  chk_fall_a: assert property ($fell(timer_a_overflow_flag)
    |-> $past(vector_ack.timer_a_vector_ack) || $past(wr_r)) else $error("flag a cleared alone");
  chk_rose_a: assert property ($rose(timer_a_overflow_flag)
    |-> $past(run_sh[0]) || $past(wr_r && hwdata[5])) else $error("flag a set while stopped");
  chk_rose_b: assert property ($rose(timer_b_overflow_flag)
    |-> $past(run_sh[1]) || $past(wr_r && hwdata[7])) else $error("flag b set while stopped");
  cover property (ap && !hwrite && haddr[9:0] == {IDX_TIMER_MODE_CONTROL, 2'b00});
  cover property ($rose(timer_a_overflow_flag));
  cover property ($rose(timer_b_overflow_flag));
endmodule : dtc_assertions

bind dtc_timer_pair dtc_assertions #(.CLK_DIV(CLK_DIV)) i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .vector_ack, .timer_a_overflow_flag,
  .timer_b_overflow_flag);

/* verif/dtc_pin_model.sv */
/*
  Far side pins: gate levels and count pin low pulses.
  Assumes one-cycle requests, at least seven clocks apart.
*/
`timescale 1ns/1ps
module dtc_pin_model
  import dtc_pkg::*;
(
  // Clock
  input  wire logic       hclk,
  // Commands
  input  wire logic [1:0] gate_lvl,
  input  wire logic [1:0] fall_req,
  // Pins
  output dtc_pins_t       timer_pins
);
  int low_cnt [2];
  // Low phase of three clocks, longer than the one the edge detector needs
  always @(posedge hclk)
    for (int i = 0; i < 2; i++)
      low_cnt[i] <= fall_req[i] ? 3 : (low_cnt[i] > 0 ? low_cnt[i] - 1 : 0);
  // Gate levels change right after an edge, as the design expects
  assign timer_pins = {gate_lvl[1], gate_lvl[0], low_cnt[1] == 0, low_cnt[0] == 0};
endmodule : dtc_pin_model

/* verif/tb_dual_timer_counter_pair.sv */
/*
  Self-checking bench of the timer pair with an integer model of both timers.
  Assumes a zero wait state slave and a free running divider from reset.
*/
`timescale 1ns/1ps
module tb_dual_timer_counter_pair;
  import dtc_pkg::*;
  localparam int DIV = 2;
  logic        hclk = 0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        flag_a;
  logic        flag_b;
  dtc_pins_t   pins;
  dtc_ack_t    ack;
  logic [1:0]  gate_lvl;
  logic [1:0]  fall_req;
  logic [31:0] lfsr = 32'h3733272d;
  logic [7:0]  ridx [7] = '{IDX_TIMER_A_LOW_BYTE, IDX_TIMER_A_HIGH_BYTE, IDX_TIMER_B_LOW_BYTE,
    IDX_TIMER_B_HIGH_BYTE, IDX_TIMER_MODE_CONTROL, IDX_TIMER_RUN_FLAGS, 8'hff};
  int          cyc;
  int          tend;
  int          err_count;
  int          checks_done;
  always #2 hclk = ~hclk;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cyc <= 0;
    else cyc <= cyc + 1;
  dtc_timer_pair #(.CLK_DIV(DIV)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer_pins(pins), .vector_ack(ack),
    .timer_a_overflow_flag(flag_a), .timer_b_overflow_flag(flag_b));
  dtc_pin_model i_pins (.hclk, .gate_lvl, .fall_req, .timer_pins(pins));

  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd8

  // Value is hi*256+lo, bit 16 marks an overflow
  function automatic int cnt(input int m, lo, hi, n);
    int v;
    int ov;
    v = hi * 256 + lo;
    ov = 0;
    for (int i = 0; i < n; i++)
    begin
      case (m)
        0: v = (v & 31) == 31 ? (v & 'hffe0) + 256 : v + 1;
        1: v = v + 1;
        2: v = (v & 255) == 255 ? (v & 'hff00) + (v >> 8) + 65536 : v + 1;
        default: v = (v & 'hff00) + ((v + 1) & 255) + ((v & 255) == 255 ? 65536 : 0);
      endcase
      ov |= v >> 16;
      v &= 'hffff;
    end
    return v + ov * 65536;
  endfunction : cnt

  function automatic logic [33:0] model(input logic [7:0] md, al, ah, bl, bh, input logic [1:0] g,
    input int t, f);
    int na;
    int nb;
    int ra;
    int rb;
    int rh;
    na = (md[3] && !g[0]) || md[2] ? 0 : t;
    nb = (md[7] && !g[1]) || md[5:4] == 2'h3 ? 0 : (md[6] ? f : t);
    ra = cnt(md[1:0], al, ah, na);
    rb = cnt(md[5:4], bl, bh, nb);
    if (md[1:0] == 2'h3)
    begin
      rh = cnt(3, ah, 0, t);
      ra = (ra & 'h100ff) | ((rh & 255) << 8);
      rb = (rb & 'hffff) | (rh & 'h10000);
    end
    return {rb[16], ra[16], rb[15:0], ra[15:0]};
  endfunction : model

  task automatic give_verdict(input bit hang);
    if (hang) err_count++;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) give_verdict(1);
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] idx, wd, output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {rnd8(), rnd8(), rnd8(), wd};
    wait_rdy();
    rd = hrdata[7:0];
    tend = cyc + 1;
  endtask : xfer

  task automatic window(input logic [7:0] md, al, ah, bl, bh, input logic [1:0] g, input int k, f);
    logic [7:0]  rd;
    logic [33:0] e;
    int          ew;
    int          ei;
    xfer(1, IDX_TIMER_MODE_CONTROL, md, rd);
    xfer(1, IDX_TIMER_A_LOW_BYTE, al, rd);
    xfer(1, IDX_TIMER_A_HIGH_BYTE, ah, rd);
    xfer(1, IDX_TIMER_B_LOW_BYTE, bl, rd);
    xfer(1, IDX_TIMER_B_HIGH_BYTE, bh, rd);
    gate_lvl <= g;
    xfer(1, IDX_TIMER_RUN_FLAGS, 8'h50, rd);
    ew = tend;
    for (int i = 0; i < k; i++)
    begin
      fall_req <= (i % 7 == 1 && i / 7 < f) ? 2'b10 : 2'b00;
      @(posedge hclk);
    end
    #1;
    ei = cyc;
    e = model(md, al, ah, bl, bh, g, ei / DIV - ew / DIV, f);
    chk("flag a", flag_a, e[32]);
    chk("flag b", flag_b, e[33]);
    // Bus changes only on an edge, so the stop lands two edges after this one
    @(posedge hclk);
    xfer(1, IDX_TIMER_RUN_FLAGS, 8'h00, rd);
    e = model(md, al, ah, bl, bh, g, (ei + 3) / DIV - ew / DIV, f);
    for (int i = 0; i < 4; i++)
    begin
      xfer(0, ridx[i], 8'h00, rd);
      chk("data byte", rd, e[8 * i +: 8]);
    end
  endtask : window

  initial
  begin
    logic [7:0] rd;
    logic [7:0] v;
    {hsel, haddr, htrans, hwrite, hwdata, gate_lvl, fall_req, ack, hresetn} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++)
    begin
      xfer(0, ridx[i], 8'h00, rd);
      chk("reset value", rd, 8'h00);
    end
    for (int i = 0; i < 7; i++)
    begin
      if (i == 5) continue;
      v = rnd8();
      xfer(1, ridx[i], v, rd);
      xfer(0, ridx[i], 8'h00, rd);
      chk("readback", rd, i == 6 ? 8'h00 : v);
    end
    // Every mode on both timers; high bytes near the top so overflows happen
    for (int m = 0; m < 4; m++)
      window({2'b00, m[1:0], 2'b00, m[1:0]}, rnd8() | 8'hf0, 8'hff, rnd8() | 8'hf0, rnd8() | 8'hf0,
        2'b00, 20 + int'(rnd8() % 16), 0);
    window(8'hd9, 8'hfe, 8'hff, 8'hfe, 8'hff, 2'b10, 40, 3);
    window(8'hd9, 8'hfe, 8'hff, 8'hfe, 8'hff, 2'b01, 40, 3);
    xfer(1, IDX_TIMER_RUN_FLAGS, 8'ha0, rd);
    #1;
    chk("flags set", {flag_b, flag_a}, 8'h03);
    @(posedge hclk);
    ack <= 2'b11;
    @(posedge hclk);
    ack <= 2'b00;
    #1;
    chk("flags acked", {flag_b, flag_a}, 8'h00);
    give_verdict(0);
  end
endmodule : tb_dual_timer_counter_pair
